// [src/pssq_sequencer.sv]
// Power-state sequencer: reset, standby, regulator enabling, trim/latch,
// normal and regulator disabling, plus wake detection and rate decoding.
// Assumes pins arrive asynchronously; the analog wake-pin RC delay sits
// outside, ahead of SLEEP_WAKE_PIN_IN. POR inputs are high while in reset.
module pssq_sequencer
    import pssq_pkg::*;
#(
    parameter int WAKE_TIMEOUT = WAKE_TIMEOUT_CYC,
    parameter int MIN_PULSES = MIN_WAKE_PULSE_COUNT,
    parameter int DEGLITCH = WAKE_PIN_FILTER_CYC,
    parameter int STBY_DIV = STANDBY_OSC_DIV
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic STANDBY_POWER_ON_RESET,
    input wire logic MAIN_POWER_ON_RESET,
    input wire logic SLEEP_WAKE_PIN_IN,
    input wire logic ISOLATED_LINE_IN,
    input wire logic [3:0] COMPARATOR_CODE,
    input wire logic BIST_DONE,
    input wire logic BIST_PASS,
    input wire logic MASTER_ROLE_SELECT,
    input wire logic CLOCK_PHASE_IN,
    input wire logic CLOCK_POLARITY_IN,
    output pssq_power_t POWER_EN,
    output logic BIST_START,
    output pssq_cfg_t CFG,
    output pssq_rate_t MASTER_CLOCK_RATE,
    output logic MASTER_RATE_VALID,
    output logic FIRST_POWERUP_FLAG,
    output logic SLEEP_REQUEST,
    output logic IFACE_ENABLE,
    output pssq_state_t STATE
);

    localparam int TW = $clog2(WAKE_TIMEOUT + 1);
    localparam int PW = $clog2(MIN_PULSES + 1);
    localparam int DW = $clog2(STBY_DIV);
    localparam logic [TW-1:0] TIMEOUT_C = TW'(WAKE_TIMEOUT);
    localparam logic [PW-1:0] PULSES_C = PW'(MIN_PULSES);
    localparam logic [DW-1:0] DIV_LAST = DW'(STBY_DIV - 1);

    // Synchroniser stages for every pin
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [3:0] code_s1_reg;
    logic [3:0] code_s2_reg;
    logic stby_por;
    logic main_por;
    logic wake_pin;
    logic iso_line;
    logic bist_done;
    logic bist_pass;

    // Two flops on each asynchronous input
    always_ff @(posedge CORE_CLK) begin
        sync1_reg <= {STANDBY_POWER_ON_RESET, MAIN_POWER_ON_RESET, SLEEP_WAKE_PIN_IN,
                      ISOLATED_LINE_IN, BIST_DONE, BIST_PASS};
        sync2_reg <= sync1_reg;
        code_s1_reg <= COMPARATOR_CODE;
        code_s2_reg <= code_s1_reg;
    end

    assign stby_por = sync2_reg[5];
    assign main_por = sync2_reg[4];
    assign wake_pin = sync2_reg[3];
    assign iso_line = sync2_reg[2];
    assign bist_done = sync2_reg[1];
    assign bist_pass = sync2_reg[0];

    // Straps pass two flops as well; only the trim-completing edge reads them
    logic [2:0] strap_s1_reg;
    logic [2:0] strap_s2_reg;

    always_ff @(posedge CORE_CLK) begin
        strap_s1_reg <= {MASTER_ROLE_SELECT, CLOCK_PHASE_IN, CLOCK_POLARITY_IN};
        strap_s2_reg <= strap_s1_reg;
    end

    // Whole block held inert while either reset is active
    logic hold_reset;
    assign hold_reset = SRST || stby_por;

    pssq_state_t state_reg;
    pssq_state_t state_next;
    logic flag_reg;
    logic flag_next;
    pssq_cfg_t cfg_reg;
    pssq_cfg_t cfg_next;
    logic iso_prev_reg;

    // Standby oscillator as an enable pulse
    logic [DW-1:0] div_reg;
    logic stby_tick;
    assign stby_tick = (div_reg == DIV_LAST);

    always_ff @(posedge CORE_CLK) begin
        if (hold_reset) begin
            div_reg <= '0;
        end else begin
            div_reg <= stby_tick ? '0 : div_reg + 1'b1;
        end
    end

    // Wake sources are armed only in standby with the flag set
    logic listen_stby;
    logic listen_normal;
    assign listen_stby = (state_reg == PSSQ_STANDBY) && flag_reg;
    assign listen_normal = (state_reg == PSSQ_NORMAL);

    // Released wake pin must hold through one standby period
    logic pin_wake;
    pssq_filter #(
        .COUNT(STANDBY_FILTER_TICKS)
    ) u_stby_filter (
        .clk(CORE_CLK),
        .srst(hold_reset),
        .en(stby_tick),
        .clr(!listen_stby),
        .din(wake_pin),
        .q(pin_wake)
    );

    // Main-domain deglitch of the wake pin for go-to-sleep
    logic pin_sleep;
    pssq_filter #(
        .COUNT(DEGLITCH)
    ) u_main_deglitch (
        .clk(CORE_CLK),
        .srst(hold_reset),
        .en(1'b1),
        .clr(!listen_normal),
        .din(wake_pin),
        .q(pin_sleep)
    );

    // Isolated-line pulse counter within a timeout window
    logic [PW-1:0] pulse_reg;
    logic [PW-1:0] pulse_next;
    logic [TW-1:0] win_reg;
    logic [TW-1:0] win_next;
    logic win_open;
    logic iso_rise;
    logic iso_wake;
    logic win_expired;

    assign iso_rise = iso_line && !iso_prev_reg;
    assign win_open = (pulse_reg != '0);
    assign win_expired = win_open && (win_reg == TIMEOUT_C);
    assign iso_wake = listen_stby && (pulse_reg == PULSES_C);
    assign pulse_next = (!listen_stby || win_expired) ? '0 :
                        (iso_rise && pulse_reg != PULSES_C) ? pulse_reg + 1'b1 : pulse_reg;
    assign win_next = (!listen_stby || win_expired || !win_open) ? '0 : win_reg + 1'b1;

    always_ff @(posedge CORE_CLK) begin
        if (hold_reset) begin
            pulse_reg <= '0;
            win_reg <= '0;
            iso_prev_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
            win_reg <= win_next;
            iso_prev_reg <= iso_line;
        end
    end

    // Either wake source starts the uninterruptible wake-up sequence
    logic wake_any;
    assign wake_any = pin_wake || iso_wake;

    // Self-test verdict chooses measured code or slowest setting
    logic [3:0] latched_code;
    assign latched_code = bist_pass ? code_s2_reg : 4'h0;
    logic trim_done;
    assign trim_done = (state_reg == PSSQ_TRIM_LATCH) && bist_done;

    // Next-state selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSSQ_RESET: begin
                state_next = PSSQ_STANDBY;
            end
            PSSQ_STANDBY: begin
                if (!flag_reg) begin
                    state_next = PSSQ_REG_ENABLE;
                end else if (wake_any) begin
                    state_next = PSSQ_REG_ENABLE;
                end
            end
            PSSQ_REG_ENABLE: begin
                if (!main_por) begin
                    state_next = flag_reg ? PSSQ_NORMAL : PSSQ_TRIM_LATCH;
                end
            end
            PSSQ_TRIM_LATCH: begin
                if (trim_done) begin
                    state_next = PSSQ_NORMAL;
                end
            end
            PSSQ_NORMAL: begin
                if (pin_sleep) begin
                    state_next = PSSQ_REG_DISABLE;
                end
            end
            PSSQ_REG_DISABLE: begin
                if (main_por) begin
                    state_next = PSSQ_STANDBY;
                end
            end
            default: state_next = PSSQ_RESET;
        endcase
    end

    // Standby registers: flag and latched configuration
    assign flag_next = flag_reg || trim_done;
    assign cfg_next = trim_done ? pssq_cfg_t'({strap_s2_reg, latched_code}) : cfg_reg;

    always_ff @(posedge CORE_CLK) begin
        if (hold_reset) begin
            state_reg <= PSSQ_RESET;
            flag_reg <= 1'b0;
            cfg_reg <= CFG_RESET;
        end else begin
            state_reg <= state_next;
            flag_reg <= flag_next;
            cfg_reg <= cfg_next;
        end
    end

    // Power enables follow the state
    pssq_power_t power_next;
    pssq_power_t power_reg;
    assign power_next.core_regulator = (state_next == PSSQ_REG_ENABLE) ||
                                       (state_next == PSSQ_TRIM_LATCH) ||
                                       (state_next == PSSQ_NORMAL);
    assign power_next.main_oscillator = power_next.core_regulator;
    assign power_next.rate_sense = (state_next == PSSQ_TRIM_LATCH);

    always_ff @(posedge CORE_CLK) begin
        if (hold_reset) begin
            power_reg <= '0;
        end else begin
            power_reg <= power_next;
        end
    end

    // Outputs
    assign POWER_EN = power_reg;
    assign BIST_START = power_reg.rate_sense;
    assign CFG = cfg_reg;
    assign MASTER_CLOCK_RATE = cfg_reg.master_role_select ?
                               pssq_decode_rate(cfg_reg.rate_code) : PSSQ_RATE_250K;
    assign MASTER_RATE_VALID = cfg_reg.master_role_select && flag_reg;
    assign FIRST_POWERUP_FLAG = flag_reg;
    assign SLEEP_REQUEST = pin_sleep;
    assign IFACE_ENABLE = (state_reg == PSSQ_NORMAL);
    assign STATE = state_reg;

endmodule

// [src/pssq_pkg.sv]
// Constants, types and the rate decoder of the power-state sequencer.
// Assumes a single 100 MHz core clock with a synchronous active-high reset.
// Operation
// - Latch 4-bit comparator code in trim state; it sets rate only as master.
// - Code 0111 gives 8 MHz, 0011 4 MHz, 0001 1 MHz, others 250 kHz.
// - Self-test the four comparators while in the trim state.
// - On failed self-test store 250 kHz instead of the measured code.
// - Leaving trim switches off bias current, comparators and sensing divider.
// - First power-up walks reset, standby, regulator enabling, trim, normal.
// - Later wake-up walks standby, regulator enabling, normal, skipping trim.
// - Go-to-sleep walks normal, regulator disabling, standby.
// - While held in reset by low supply, nothing operates.
// - Sleep only after wake pin rises in normal, filtered analog plus deglitch counter.
// - Standby is entered from reset only at first power-up after standby POR release.
// - In standby with flag 0, go to regulator enabling whatever wake sources do.
// - In standby with flag 1, stay until a wake-up source is asserted.
// - Wake pin release wakes; filtered by analog delay plus one standby clock period.
// - Wake when enough pulses on the isolated line arrive within a timeout window.
// - Regulator enabling turns on the core regulator and main oscillator.
// - Regulator enabling ignores wake pin, SPI and isolated line; no abort.
// - Leave regulator enabling on main POR release: trim if flag 0, else normal.
// - Trim latches master select, clock phase, polarity and rate into standby registers.
// - Completing trim sets the first-powerup flag and moves to normal.
// - In normal a deglitched high wake pin raises the go-to-sleep request.
// - Isolated-line pulse counter timeout lies between 150 and 630 microseconds.
package pssq_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 10;

    // Wake pin deglitch time, typical figure
    localparam int WAKE_PIN_FILTER_TIME_NS = 2000;
    localparam int WAKE_PIN_FILTER_CYC = (WAKE_PIN_FILTER_TIME_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;

    // Standby oscillator, modelled as an enable divider of the core clock
    localparam int STANDBY_OSC_FREQUENCY_KHZ = 100;
    localparam int STANDBY_OSC_DIV = 1000000 / (STANDBY_OSC_FREQUENCY_KHZ * CLK_PERIOD_NS);
    // Wake pin in standby must stay released one standby period
    localparam int STANDBY_FILTER_TICKS = 1;

    // Isolated-line wake detector
    localparam int WAKE_TIMEOUT_MIN_US = 150;
    localparam int WAKE_TIMEOUT_MAX_US = 630;
    localparam int WAKE_TIMEOUT_US = 400;
    localparam int WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int MIN_WAKE_PULSE_COUNT = 8;

    // Threshold codes
    localparam logic [3:0] CODE_8MHZ = 4'h7;
    localparam logic [3:0] CODE_4MHZ = 4'h3;
    localparam logic [3:0] CODE_1MHZ = 4'h1;

    // Master clock rate selections
    typedef enum logic [1:0] {
        PSSQ_RATE_250K = 2'h0,
        PSSQ_RATE_1M = 2'h1,
        PSSQ_RATE_4M = 2'h2,
        PSSQ_RATE_8M = 2'h3
    } pssq_rate_t;

    // Sequencer states
    typedef enum logic [2:0] {
        PSSQ_RESET,
        PSSQ_STANDBY,
        PSSQ_REG_ENABLE,
        PSSQ_TRIM_LATCH,
        PSSQ_NORMAL,
        PSSQ_REG_DISABLE
    } pssq_state_t;

    // Configuration latched at first power-up
    typedef struct packed {
        logic master_role_select;
        logic clock_phase;
        logic clock_polarity;
        logic [3:0] rate_code;
    } pssq_cfg_t;

    localparam pssq_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 4'h0};

    // Power enables steered by the sequencer
    typedef struct packed {
        logic core_regulator;
        logic main_oscillator;
        logic rate_sense;
    } pssq_power_t;

    // Comparator code to master clock rate
    function automatic pssq_rate_t pssq_decode_rate(input logic [3:0] code);
        pssq_rate_t r;
        r = PSSQ_RATE_250K;
        case (code)
            CODE_8MHZ: r = PSSQ_RATE_8M;
            CODE_4MHZ: r = PSSQ_RATE_4M;
            CODE_1MHZ: r = PSSQ_RATE_1M;
            default: r = PSSQ_RATE_250K;
        endcase
        return r;
    endfunction

endpackage

// [src/pssq_filter.sv]
// Up/reset counter that declares its input high once stable for a count.
// Assumes a synchronised input and an optional enable pulse for slower rates.
module pssq_filter
    import pssq_pkg::*;
#(
    parameter int COUNT = 200
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic en,
    input wire logic clr,
    input wire logic din,
    output logic q
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] COUNT_C = CW'(COUNT);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic q_reg;
    logic q_next;

    // Any low sample restarts the count; saturate at the target
    assign cnt_next = (clr || !din) ? '0 :
                      (en && cnt_reg != COUNT_C) ? cnt_reg + 1'b1 : cnt_reg;
    assign q_next = !clr && din && (cnt_next == COUNT_C);
    assign q = q_reg;

    // Counter state
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            q_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            q_reg <= q_next;
        end
    end

endmodule

// [verif/pssq_checker.sv]
// Port checker of the power-state sequencer.
// Assumes one core clock and a synchronous active-high reset.
module pssq_checker
    import pssq_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire pssq_power_t POWER_EN,
    input wire pssq_cfg_t CFG,
    input wire pssq_rate_t MASTER_CLOCK_RATE,
    input wire logic FIRST_POWERUP_FLAG,
    input wire logic IFACE_ENABLE,
    input wire pssq_state_t STATE
);
    timeunit 1ns;
    timeprecision 1ns;
    pssq_rate_t exp_rate;
    // Rate expected from the latched code
    assign exp_rate = !CFG.master_role_select ? PSSQ_RATE_250K
        : CFG.rate_code == 4'h7 ? PSSQ_RATE_8M : CFG.rate_code == 4'h3 ? PSSQ_RATE_4M
        : CFG.rate_code == 4'h1 ? PSSQ_RATE_1M : PSSQ_RATE_250K;
    // Sampled on the core clock, quiet during reset except the reset-state check
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    reset_state_a: assert property (disable iff (1'b0) SRST |=> STATE == PSSQ_RESET)
        else $error("state not reset");
    rate_decode_a: assert property ($past(STATE) == PSSQ_NORMAL && STATE == PSSQ_NORMAL
        |-> MASTER_CLOCK_RATE == exp_rate) else $error("rate decode wrong");
    trim_exit_a: assert property ($past(STATE) == PSSQ_TRIM_LATCH && STATE != PSSQ_TRIM_LATCH
        |-> STATE == PSSQ_NORMAL && FIRST_POWERUP_FLAG) else $error("bad trim exit");
    sense_off_a: assert property (STATE != PSSQ_TRIM_LATCH |-> !POWER_EN.rate_sense)
        else $error("rate sense left on");
    reg_on_a: assert property (STATE == PSSQ_REG_ENABLE
        |-> POWER_EN.core_regulator && POWER_EN.main_oscillator) else $error("supply off");
    first_go_a: assert property (STATE == PSSQ_STANDBY && !FIRST_POWERUP_FLAG
        |=> STATE == PSSQ_REG_ENABLE) else $error("standby held");
    skip_trim_a: assert property (STATE == PSSQ_REG_ENABLE && FIRST_POWERUP_FLAG
        |=> STATE != PSSQ_TRIM_LATCH) else $error("trim on wake");
    sleep_path_a: assert property (STATE == PSSQ_NORMAL
        |=> STATE inside {PSSQ_NORMAL, PSSQ_REG_DISABLE}) else $error("bad normal exit");
    off_path_a: assert property (STATE == PSSQ_REG_DISABLE
        |=> STATE inside {PSSQ_REG_DISABLE, PSSQ_STANDBY}) else $error("bad disable exit");
    iface_on_a: assert property (IFACE_ENABLE == (STATE == PSSQ_NORMAL))
        else $error("iface enable wrong");
    wake_no_abort_a: assert property (STATE == PSSQ_REG_ENABLE
        |=> STATE inside {PSSQ_REG_ENABLE, PSSQ_TRIM_LATCH, PSSQ_NORMAL})
        else $error("wake-up aborted");
endmodule

bind pssq_sequencer pssq_checker u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST), .POWER_EN(POWER_EN),
    .CFG(CFG), .MASTER_CLOCK_RATE(MASTER_CLOCK_RATE), .FIRST_POWERUP_FLAG(FIRST_POWERUP_FLAG),
    .IFACE_ENABLE(IFACE_ENABLE), .STATE(STATE));

// [verif/pssq_host_model.sv]
// Host on the wake pin plus the main supply monitor.
// Assumes the bench commands pin release; the pin has a pull-up.
module pssq_host_model
    import pssq_pkg::*;
(
    input wire logic clk,
    input wire logic release_pin,
    input wire pssq_power_t power_en,
    output logic wake_pin,
    output logic main_por
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // Open drain low unless released, pull-up gives high
    assign wake_pin = release_pin ? 1'b1 : 1'b0;
    initial begin
        main_por = 1'b1;
        cnt = 4'h0;
    end
    // Main POR follows the regulator after a settling delay
    always @(posedge clk) begin
        cnt <= (main_por == power_en.core_regulator) ? cnt + 4'h1 : 4'h0;
        if (cnt == 4'h9) main_por <= ~main_por;
    end
endmodule

// [verif/tb_pssq_sequencer.sv]
// Testbench of the power-state sequencer with short filter counts.
// Assumes the host model drives the wake pin and main POR.
module tb_pssq_sequencer import pssq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, stby_por = 1'b1, iso = 1'b0, bist_done = 1'b0;
    logic bist_pass = 1'b0, master = 1'b0, release_pin = 1'b0, saw_trim = 1'b0;
    logic [3:0] code = 4'h0;
    logic wake_pin, main_por, bist_start, rate_valid, flag, sleep_req, iface;
    pssq_power_t pwr;
    pssq_cfg_t cfg;
    pssq_rate_t rate;
    pssq_state_t state;
    int num_errors = 0;
    int compares = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (state === PSSQ_TRIM_LATCH) saw_trim <= 1'b1;
    pssq_host_model u_host (.clk(clk), .release_pin(release_pin), .power_en(pwr),
        .wake_pin(wake_pin), .main_por(main_por));
    pssq_sequencer #(.WAKE_TIMEOUT(50), .MIN_PULSES(8), .DEGLITCH(5), .STBY_DIV(4)) u_dut (
        .CORE_CLK(clk), .SRST(srst), .STANDBY_POWER_ON_RESET(stby_por),
        .MAIN_POWER_ON_RESET(main_por), .SLEEP_WAKE_PIN_IN(wake_pin), .ISOLATED_LINE_IN(iso),
        .COMPARATOR_CODE(code), .BIST_DONE(bist_done), .BIST_PASS(bist_pass),
        .MASTER_ROLE_SELECT(master), .CLOCK_PHASE_IN(bist_pass), .CLOCK_POLARITY_IN(~master),
        .POWER_EN(pwr), .BIST_START(bist_start), .CFG(cfg), .MASTER_CLOCK_RATE(rate),
        .MASTER_RATE_VALID(rate_valid), .FIRST_POWERUP_FLAG(flag), .SLEEP_REQUEST(sleep_req),
        .IFACE_ENABLE(iface), .STATE(state));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait for a state
    task automatic wait_state(input pssq_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 3000) begin
            step(1);
            n++;
        end
        check("state wait", state, s);
        if (n == 3000) print_verdict();
    endtask
    // First power-up with one code, self-test result and role
    task automatic power_up(input logic [3:0] c, input logic pass, input logic mst);
        logic [1:0] exp;
        exp = (!pass || !mst) ? 2'h0 : c == 4'h7 ? 2'h3 : c == 4'h3 ? 2'h2 : c == 4'h1 ? 2'h1 : 2'h0;
        srst = 1'b1;
        stby_por = 1'b1;
        {code, bist_pass, master} = {c, pass, mst};
        step(6);
        srst = 1'b0;
        step(2);
        check("por hold", state, PSSQ_RESET);
        check("por power", pwr, 3'h0);
        stby_por = 1'b0;
        step(3);
        check("standby", state, PSSQ_STANDBY);
        step(1);
        check("reg enable", state, PSSQ_REG_ENABLE);
        check("power", pwr, 3'h6);
        wait_state(PSSQ_TRIM_LATCH);
        check("bist start", bist_start, 1'b1);
        step(3);
        bist_done = 1'b1;
        wait_state(PSSQ_NORMAL);
        bist_done = 1'b0;
        check("power off", pwr, 3'h6);
        check("flag", flag, 1'b1);
        check("rate valid", rate_valid, mst);
        check("cfg", cfg, {mst, pass, ~mst, pass ? c : 4'h0});
        step(1);
        check("rate", rate, exp);
    endtask
    // Glitch kept out, then real sleep on a held release, then host holding low in standby
    task automatic go_sleep();
        release_pin = 1'b1;
        step(3);
        release_pin = 1'b0;
        step(10);
        check("glitch", state, PSSQ_NORMAL);
        check("no sleep req", sleep_req, 1'b0);
        check("iface on", iface, 1'b1);
        release_pin = 1'b1;
        wait_state(PSSQ_REG_DISABLE);
        check("sleep req", sleep_req, 1'b1);
        release_pin = 1'b0;
        wait_state(PSSQ_STANDBY);
        check("iface off", iface, 1'b0);
        step(100);
        check("stay", state, PSSQ_STANDBY);
    endtask
    // Wake by pin release, trim skipped
    task automatic wake_pin_rel();
        saw_trim = 1'b0;
        release_pin = 1'b1;
        wait_state(PSSQ_REG_ENABLE);
        release_pin = 1'b0;
        wait_state(PSSQ_NORMAL);
        check("trim", saw_trim, 1'b0);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            iso = 1'b1;
            step(2);
            iso = 1'b0;
            step(2);
        end
    endtask
    // Seven pulses do not wake, eight do
    task automatic wake_iso();
        pulses(7);
        step(80);
        check("seven", state, PSSQ_STANDBY);
        pulses(8);
        wait_state(PSSQ_REG_ENABLE);
        wait_state(PSSQ_NORMAL);
    endtask
    initial begin
        static logic [3:0] codes [6] = '{4'h7, 4'h3, 4'h1, 4'h0, 4'h2, 4'hf};
        foreach (codes[i]) power_up(codes[i], 1'b1, 1'b1);
        // Failed self-test falls back to the slowest rate the host must tolerate
        power_up(4'h7, 1'b0, 1'b1);
        power_up(4'h3, 1'b1, 1'b0);
        go_sleep();
        wake_pin_rel();
        go_sleep();
        wake_iso();
        print_verdict();
    end
endmodule
